// [option_decoder_consts.vh]
/*
 * Constants for the option byte configuration decoder: register offsets,
 * option bit positions, erased values, reset phase lengths and state codes.
 * Assumes it is included by its bare name from each design file.
 */
// Overview of operation
// - Erased option bits read one, FFh defaults
// - Option bytes reachable only in programming mode
// - Halt entry resets when selected and watchdog active
// - Bit 6 zero: watchdog always on in hardware
// - Bit 5 zero PLL clock, one oscillator
// - Bits 4:3 decode the two voltage detector enables
// - Bit 2 picks 4096 or 256 cycle phase
// - PLL selected forces the 4096 cycle phase
// - Bit 1 zero halves the oscillator input
// - Bit 0 zero blocks test and in-circuit access
// - Protected option erase wipes user memory first
// - Byte one bits 7:5 select the package
// - Byte one bits 1:0 set motor reset state
`ifndef OPTION_DECODER_CONSTS_VH
`define OPTION_DECODER_CONSTS_VH

// APB byte addresses.
`define ADDR_PROG_CTRL 12'h000
`define ADDR_PROG_DATA 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_STORE_READ 12'h00C

// Programming control bits.
`define CTRL_PROGRAM 0
`define CTRL_ERASE 1

// Status bits.
`define STAT_BUSY 0
`define STAT_MEM_ERASE 1
`define STAT_ERROR 2
`define STAT_CPU_RESET 3
`define STAT_HALTED 4
`define STAT_PROTECT 5

// Option byte zero fields.
`define OB0_HALT_RESET 7
`define OB0_WATCHDOG 6
`define OB0_CLK_SRC 5
`define OB0_VDET_HI 4
`define OB0_VDET_LO 3
`define OB0_RST_LEN 2
`define OB0_HALVING 1
`define OB0_PROTECT 0

// Option byte one fields.
`define OB1_PACK_HI 7
`define OB1_PACK_LO 5
`define OB1_MOTOR_HI 1
`define OB1_MOTOR_LO 0

`define OPTION_ERASED 16'hFFFF
`define BYTE_ERASED 8'hFF

// Voltage detect codes.
`define VDET_BOTH_ON 2'h0
`define VDET_LOW_ONLY 2'h1
`define VDET_BOTH_OFF 2'h2
`define VDET_BOTH_ON_ALT 2'h3

// Motor output reset state codes.
`define MOTOR_LOW 2'h1
`define MOTOR_HIGH 2'h2

// Reset phase lengths in CPU cycles.
`define RESET_LONG_CYCLES 4096
`define RESET_SHORT_CYCLES 256

// Sequencer states.
`define SQ_LOAD 3'h0
`define SQ_LATCH 3'h1
`define SQ_PHASE 3'h2
`define SQ_RUN 3'h3
`define SQ_HALT 3'h4
`define SQ_WAKE 3'h5

// Programming states.
`define PG_IDLE 2'h0
`define PG_WRITE 2'h1
`define PG_MEM_ERASE 2'h2
`define PG_OPT_ERASE 2'h3

`endif

// [option_store.v]
/*
 * Nonvolatile store for the two option bytes, with registered read data.
 * Assumes the controller only starts writes or erases in programming mode; a protected erase may finish after it ends.
 */
`timescale 1ns/1ps
`include "option_decoder_consts.vh"

module option_store #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Update port
  input wire wr_en,
  input wire erase,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  output reg [WIDTH-1:0] rd_data
);

  // Contents survive reset, as the cells are nonvolatile; a fresh part
  // starts erased.
  reg [WIDTH-1:0] mem;

  initial begin
    mem = `OPTION_ERASED;
  end

  always @(posedge clk) begin
    if (erase) begin
      mem <= `OPTION_ERASED;
    end else if (wr_en) begin
      mem <= wr_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `OPTION_ERASED;
    end else begin
      rd_data <= mem;
    end
  end

endmodule

// [option_byte_config_decoder.v]
/*
 * Option byte configuration decoder: APB programming access to the option
 * store, latching and decoding of the settings, reset phase and halt
 * sequencing. Assumes pclk is the CPU clock and all inputs are synchronous
 * to it; the programming tool drives programming_mode.
 */
`timescale 1ns/1ps
`include "option_decoder_consts.vh"

module option_byte_config_decoder #(
  parameter LONG_CYCLES = `RESET_LONG_CYCLES,
  parameter SHORT_CYCLES = `RESET_SHORT_CYCLES,
  parameter CNT_W = 13
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Mode inputs
  input wire programming_mode,
  input wire in_circuit_programming_mode,
  input wire test_mode,
  // User memory erase handshake
  output reg user_mem_erase_req,
  input wire user_mem_erase_done,
  // Power mode and watchdog
  input wire halt_entry,
  input wire wakeup,
  input wire sw_watchdog_enable,
  output reg cpu_reset_n,
  output reg cpu_halted,
  output reg halt_reset_event,
  output reg halt_exit_done,
  // Decoded configuration
  output reg halt_entry_reset_select,
  output reg watchdog_type_select,
  output reg watchdog_hw_enable,
  output wire watchdog_active,
  output reg clock_source_select,
  output reg [1:0] voltage_detect_select,
  output reg low_voltage_detector,
  output reg auxiliary_voltage_detector,
  output reg reset_length_select,
  output reg input_halving_divider,
  output wire oscillator_input_en,
  output reg readout_protect,
  output wire flash_read_block,
  output wire flash_write_block,
  output reg [2:0] package_select,
  output reg package_largest,
  output reg motor_output_reset_state,
  output reg motor_output_drive_n
);

  localparam [CNT_W-1:0] LONG_CNT = LONG_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] SHORT_CNT = SHORT_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ************************************************************
  // Option store
  // ************************************************************
  reg store_wr;
  reg store_erase;
  reg [15:0] prog_data;
  wire [15:0] store_q;

  option_store #(
    .WIDTH(16)
  ) store (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(store_wr),
    .erase(store_erase),
    .wr_data(prog_data),
    .rd_data(store_q)
  );

  // ************************************************************
  // APB slave
  // ************************************************************
  wire access = psel && penable;
  wire addr_ok = (paddr == `ADDR_PROG_CTRL) || (paddr == `ADDR_PROG_DATA) ||
                 (paddr == `ADDR_STATUS) || (paddr == `ADDR_STORE_READ);
  // The option bytes are not part of the memory map seen by the program:
  // outside programming mode every access is refused.
  wire allowed = programming_mode && addr_ok;
  wire wr_ok = access && pwrite && allowed;
  wire wr_ctrl = wr_ok && (paddr == `ADDR_PROG_CTRL);
  wire wr_data_reg = wr_ok && (paddr == `ADDR_PROG_DATA);
  wire wr_status = wr_ok && (paddr == `ADDR_STATUS);

  reg [1:0] pg_state;
  reg prog_error;
  reg [31:0] rd_mux;

  wire [31:0] status_word = {26'h000_0000, readout_protect, cpu_halted,
                             ~cpu_reset_n, prog_error,
                             (pg_state == `PG_MEM_ERASE),
                             (pg_state != `PG_IDLE)};

  always @* begin
    rd_mux = 32'h0000_0000;
    if (allowed) begin
      case (paddr)
        `ADDR_PROG_DATA: rd_mux = {16'h0000, prog_data};
        `ADDR_STATUS: rd_mux = status_word;
        `ADDR_STORE_READ: rd_mux = {16'h0000, store_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = access && !allowed;
  assign prdata = (access && !pwrite) ? rd_mux : 32'h0000_0000;

  // ************************************************************
  // Programming sequencer
  // ************************************************************
  // A program or erase request that arrives while busy is refused and
  // flagged, rather than queued, so the tool sees every command lost while busy.
  wire cmd_prog = wr_ctrl && pwdata[`CTRL_PROGRAM];
  wire cmd_erase = wr_ctrl && pwdata[`CTRL_ERASE];
  wire store_protected = !store_q[`OB0_PROTECT];
  reg set_error;
  reg [1:0] next_pg_state;

  always @* begin
    next_pg_state = pg_state;
    set_error = 1'b0;
    case (pg_state)
      `PG_IDLE: begin
        if (cmd_erase) begin
          if (store_protected) begin
            next_pg_state = `PG_MEM_ERASE;
          end else begin
            next_pg_state = `PG_OPT_ERASE;
          end
        end else if (cmd_prog) begin
          // Once protected, only an erase opens the bytes again.
          if (store_protected) begin
            set_error = 1'b1;
          end else begin
            next_pg_state = `PG_WRITE;
          end
        end
      end
      `PG_WRITE: begin
        next_pg_state = `PG_IDLE;
        set_error = cmd_prog || cmd_erase;
      end
      `PG_MEM_ERASE: begin
        set_error = cmd_prog || cmd_erase;
        if (user_mem_erase_done) begin
          next_pg_state = `PG_OPT_ERASE;
        end
      end
      `PG_OPT_ERASE: begin
        next_pg_state = `PG_IDLE;
        set_error = cmd_prog || cmd_erase;
      end
      default: next_pg_state = `PG_IDLE;
    endcase
    // Leaving programming mode cannot stop a write already issued to the store, and an erase of
    // a protected part always runs to completion.
    if (!programming_mode && pg_state == `PG_WRITE) begin
      next_pg_state = `PG_IDLE;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_state <= `PG_IDLE;
      prog_data <= `OPTION_ERASED;
      prog_error <= 1'b0;
      store_wr <= 1'b0;
      store_erase <= 1'b0;
      user_mem_erase_req <= 1'b0;
    end else begin
      pg_state <= next_pg_state;
      if (wr_data_reg) begin
        prog_data <= pwdata[15:0];
      end
      // Set wins over a clear in the same cycle.
      if (set_error) begin
        prog_error <= 1'b1;
      end else if (wr_status && pwdata[`STAT_ERROR]) begin
        prog_error <= 1'b0;
      end
      store_wr <= (next_pg_state == `PG_WRITE) && programming_mode;
      store_erase <= (next_pg_state == `PG_OPT_ERASE);
      user_mem_erase_req <= (next_pg_state == `PG_MEM_ERASE);
    end
  end

  // ************************************************************
  // Reset phase and halt sequencer
  // ************************************************************
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] count;
  reg [CNT_W-1:0] next_count;
  reg next_halt_reset_event;

  assign watchdog_active = watchdog_hw_enable || sw_watchdog_enable;

  // PLL selection overrides the short phase setting.
  wire long_phase = !clock_source_select || !reset_length_select;
  wire [CNT_W-1:0] phase_cnt = long_phase ? LONG_CNT : SHORT_CNT;

  always @* begin
    next_state = state;
    next_count = count;
    next_halt_reset_event = 1'b0;
    case (state)
      `SQ_LOAD: next_state = `SQ_LATCH;
      `SQ_LATCH: begin
        next_state = `SQ_PHASE;
        next_count = CNT_ONE;
      end
      `SQ_PHASE: begin
        if (count == phase_cnt) begin
          next_state = `SQ_RUN;
        end else begin
          next_count = count + CNT_ONE;
        end
      end
      `SQ_RUN: begin
        if (halt_entry) begin
          if (halt_entry_reset_select && watchdog_active) begin
            next_state = `SQ_LOAD;
            next_halt_reset_event = 1'b1;
          end else begin
            next_state = `SQ_HALT;
          end
        end
      end
      `SQ_HALT: begin
        if (wakeup) begin
          next_state = `SQ_WAKE;
          next_count = CNT_ONE;
        end
      end
      `SQ_WAKE: begin
        if (count == phase_cnt) begin
          next_state = `SQ_RUN;
        end else begin
          next_count = count + CNT_ONE;
        end
      end
      default: next_state = `SQ_LOAD;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= `SQ_LOAD;
      count <= {CNT_W{1'b0}};
      cpu_reset_n <= 1'b0;
      cpu_halted <= 1'b0;
      halt_reset_event <= 1'b0;
      halt_exit_done <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      cpu_reset_n <= (next_state == `SQ_RUN) || (next_state == `SQ_HALT) ||
                     (next_state == `SQ_WAKE);
      cpu_halted <= (next_state == `SQ_HALT) || (next_state == `SQ_WAKE);
      halt_reset_event <= next_halt_reset_event;
      halt_exit_done <= (state == `SQ_WAKE) && (next_state == `SQ_RUN);
    end
  end

  // ************************************************************
  // Option latch and decode
  // ************************************************************
  // Settings are captured only in the latch step of the reset sequence,
  // so programming in run mode takes effect at the next reset.
  wire capture = (state == `SQ_LATCH);
  wire [7:0] ob0 = store_q[7:0];
  wire [7:0] ob1 = store_q[15:8];
  wire [1:0] vdet_code = ob0[`OB0_VDET_HI:`OB0_VDET_LO];
  wire [1:0] motor_code = ob1[`OB1_MOTOR_HI:`OB1_MOTOR_LO];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Until the first capture, outputs show the erased defaults.
      halt_entry_reset_select <= 1'b1;
      watchdog_type_select <= 1'b1;
      watchdog_hw_enable <= 1'b0;
      clock_source_select <= 1'b1;
      voltage_detect_select <= 2'h3;
      low_voltage_detector <= 1'b1;
      auxiliary_voltage_detector <= 1'b1;
      reset_length_select <= 1'b1;
      input_halving_divider <= 1'b0;
      readout_protect <= 1'b0;
      package_select <= 3'h7;
      package_largest <= 1'b1;
      motor_output_reset_state <= 1'b0;
      motor_output_drive_n <= 1'b1;
    end else if (capture) begin
      halt_entry_reset_select <= ob0[`OB0_HALT_RESET];
      watchdog_type_select <= ob0[`OB0_WATCHDOG];
      watchdog_hw_enable <= !ob0[`OB0_WATCHDOG];
      clock_source_select <= ob0[`OB0_CLK_SRC];
      voltage_detect_select <= vdet_code;
      // The fourth code is taken as both detectors on.
      low_voltage_detector <= (vdet_code != `VDET_BOTH_OFF);
      auxiliary_voltage_detector <= (vdet_code == `VDET_BOTH_ON) ||
                                    (vdet_code == `VDET_BOTH_ON_ALT);
      reset_length_select <= ob0[`OB0_RST_LEN];
      input_halving_divider <= !ob0[`OB0_HALVING];
      readout_protect <= !ob0[`OB0_PROTECT];
      package_select <= ob1[`OB1_PACK_HI:`OB1_PACK_LO];
      package_largest <= ob1[`OB1_PACK_HI];
      motor_output_reset_state <= (motor_code == `MOTOR_HIGH);
      motor_output_drive_n <= !((motor_code == `MOTOR_LOW) ||
                                (motor_code == `MOTOR_HIGH));
    end
  end

  // ************************************************************
  // Input halving enable
  // ************************************************************
  // A one-cycle enable at half rate stands in for a divided clock, which
  // keeps the whole block on pclk.
  reg half_phase;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_phase <= 1'b0;
    end else if (input_halving_divider) begin
      half_phase <= !half_phase;
    end else begin
      half_phase <= 1'b0;
    end
  end

  assign oscillator_input_en = !input_halving_divider || half_phase;

  // ************************************************************
  // Read-out protection
  // ************************************************************
  wire debug_access = test_mode || in_circuit_programming_mode;
  assign flash_read_block = readout_protect && debug_access;
  assign flash_write_block = readout_protect && debug_access;

endmodule

// [option_decoder_properties.sv]
/* Port checker for the option byte configuration decoder.
   Assumes it is bound to the decoder and that pclk is its only clock. */
`timescale 1ns/1ps
module option_decoder_properties #(
  parameter LONG_CYCLES = 4096,
  parameter SHORT_CYCLES = 256
) (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pslverr,
  // Modes and handshakes
  input wire programming_mode,
  input wire in_circuit_programming_mode,
  input wire test_mode,
  input wire user_mem_erase_req,
  input wire user_mem_erase_done,
  input wire halt_entry,
  input wire sw_watchdog_enable,
  input wire cpu_reset_n,
  input wire cpu_halted,
  input wire halt_reset_event,
  // Decoded settings
  input wire halt_entry_reset_select,
  input wire watchdog_type_select,
  input wire watchdog_hw_enable,
  input wire watchdog_active,
  input wire clock_source_select,
  input wire [1:0] voltage_detect_select,
  input wire low_voltage_detector,
  input wire auxiliary_voltage_detector,
  input wire reset_length_select,
  input wire input_halving_divider,
  input wire oscillator_input_en,
  input wire readout_protect,
  input wire flash_read_block,
  input wire flash_write_block,
  input wire [2:0] package_select,
  input wire package_largest
);
  // ****************************************
  // Reset phase length
  // ****************************************
  // Counts edges with the CPU held; the PLL choice overrides the short pick.
  reg [15:0] rcnt;
  wire [15:0] n_exp = (!clock_source_select || !reset_length_select) ?
    16'(LONG_CYCLES + 2) : 16'(SHORT_CYCLES + 2);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) rcnt <= 16'h0000;
    else if (cpu_reset_n) rcnt <= 16'h0000;
    else rcnt <= rcnt + 16'h0001;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_halt_go;
    halt_entry && cpu_reset_n && !cpu_halted;
  endsequence
  sequence s_halt_rst;
    s_halt_go ##0 (halt_entry_reset_select && watchdog_active);
  endsequence
  property p_defaults;
    disable iff (1'b0) !presetn |-> halt_entry_reset_select &&
      watchdog_type_select && clock_source_select && !readout_protect &&
      package_select == 3'h7 && !cpu_reset_n;
  endproperty
  property p_refuse;
    psel && penable && !programming_mode |-> pslverr && prdata == '0;
  endproperty
  property p_halt_reset;
    s_halt_rst |=> halt_reset_event && !cpu_reset_n;
  endproperty
  property p_halt_plain;
    s_halt_go ##0 !(halt_entry_reset_select && watchdog_active)
      |=> cpu_halted && !halt_reset_event;
  endproperty
  property p_watchdog;
    cpu_reset_n |-> (watchdog_hw_enable ^ watchdog_type_select) &&
      watchdog_active == (watchdog_hw_enable || sw_watchdog_enable);
  endproperty
  property p_vdet;
    cpu_reset_n |-> low_voltage_detector == (voltage_detect_select != 2'h2)
      && auxiliary_voltage_detector ==
      (voltage_detect_select[1] == voltage_detect_select[0]);
  endproperty
  property p_len;
    $rose(cpu_reset_n) |-> rcnt == n_exp;
  endproperty
  property p_halving;
    cpu_reset_n && $past(cpu_reset_n) |-> (input_halving_divider ?
      oscillator_input_en != $past(oscillator_input_en) : oscillator_input_en);
  endproperty
  property p_protect;
    cpu_reset_n |-> flash_read_block == (readout_protect &&
      (test_mode || in_circuit_programming_mode)) &&
      flash_write_block == flash_read_block;
  endproperty
  property p_erase_hold;
    user_mem_erase_req && !user_mem_erase_done |=> user_mem_erase_req;
  endproperty
  property p_package;
    cpu_reset_n |-> package_largest == package_select[2];
  endproperty
  property p_stable;
    cpu_reset_n && $past(cpu_reset_n) |-> $stable({halt_entry_reset_select,
      clock_source_select, voltage_detect_select, reset_length_select,
      readout_protect, package_select});
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults wrong in reset");
  a_refuse: assert property (p_refuse)
    else $error("access outside programming mode not refused");
  a_halt_reset: assert property (p_halt_reset)
    else $error("halt entry gave no reset");
  a_halt_plain: assert property (p_halt_plain)
    else $error("halt entry did not halt");
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog enables wrong");
  a_vdet: assert property (p_vdet)
    else $error("detector enables wrong");
  a_len: assert property (p_len)
    else $error("reset phase length wrong");
  a_halving: assert property (p_halving)
    else $error("input halving wrong");
  a_protect: assert property (p_protect)
    else $error("flash blocks wrong");
  a_erase_hold: assert property (p_erase_hold)
    else $error("memory erase request dropped early");
  a_package: assert property (p_package)
    else $error("largest package flag wrong");
  a_stable: assert property (p_stable)
    else $error("settings changed while running");
endmodule
bind option_byte_config_decoder option_decoder_properties #(
  .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_props (
  .pclk, .presetn, .psel, .penable, .prdata, .pslverr, .programming_mode,
  .in_circuit_programming_mode, .test_mode, .user_mem_erase_req,
  .user_mem_erase_done, .halt_entry, .sw_watchdog_enable, .cpu_reset_n,
  .cpu_halted, .halt_reset_event, .halt_entry_reset_select,
  .watchdog_type_select, .watchdog_hw_enable, .watchdog_active,
  .clock_source_select, .voltage_detect_select, .low_voltage_detector,
  .auxiliary_voltage_detector, .reset_length_select, .input_halving_divider,
  .oscillator_input_en, .readout_protect, .flash_read_block,
  .flash_write_block, .package_select, .package_largest);

// [user_mem_model.sv]
/* User program memory erase responder.
   Assumes the request is a level that waits for one done pulse. */
`timescale 1ns/1ps
module user_mem_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Erase handshake
  input wire req,
  input wire slow,
  output reg done
);
  reg [3:0] cnt;
  // A slow erase stretches the wait so the request must really hold.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else if (req && !done && cnt == (slow ? 4'h8 : 4'h1)) begin
      done <= 1'b1;
      cnt <= 4'h0;
    end else begin
      done <= 1'b0;
      cnt <= req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// [option_byte_config_decoder_tb_top.sv]
/* Self-checking bench for the option byte configuration decoder.
   Assumes the checker is bound and the erase responder is present. */
`timescale 1ns/1ps
module option_byte_config_decoder_tb_top;
  localparam LONG = 16;
  localparam SHORT = 4;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, programming_mode = 1'b0, slow = 1'b0;
  logic in_circuit_programming_mode = 1'b0, test_mode = 1'b0;
  logic halt_entry = 1'b0, wakeup = 1'b0, sw_watchdog_enable = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] ob, rcnt = 16'h0000;
  logic [32:0] apb_q[$], cfg_q[$];
  integer seed = 81, miscompares = 0, checks = 0, i, k;
  wire [31:0] prdata;
  wire [2:0] package_select;
  wire [1:0] voltage_detect_select;
  wire pready, pslverr, user_mem_erase_req, user_mem_erase_done;
  wire cpu_reset_n, cpu_halted, halt_reset_event, halt_exit_done;
  wire halt_entry_reset_select, watchdog_type_select, watchdog_hw_enable;
  wire watchdog_active, clock_source_select, low_voltage_detector;
  wire auxiliary_voltage_detector, reset_length_select, readout_protect;
  wire input_halving_divider, oscillator_input_en, flash_read_block;
  wire flash_write_block, package_largest, motor_output_reset_state;
  wire motor_output_drive_n;
  wire [16:0] cfg_now = {halt_entry_reset_select, watchdog_type_select,
    watchdog_hw_enable, clock_source_select, voltage_detect_select,
    low_voltage_detector, auxiliary_voltage_detector, reset_length_select,
    input_halving_divider, readout_protect, package_select, package_largest,
    motor_output_drive_n, motor_output_reset_state & ~motor_output_drive_n};
  option_byte_config_decoder #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT))
    u_option_byte_config_decoder (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .programming_mode,
    .in_circuit_programming_mode, .test_mode, .user_mem_erase_req,
    .user_mem_erase_done, .halt_entry, .wakeup, .sw_watchdog_enable,
    .cpu_reset_n, .cpu_halted, .halt_reset_event, .halt_exit_done,
    .halt_entry_reset_select, .watchdog_type_select, .watchdog_hw_enable,
    .watchdog_active, .clock_source_select, .voltage_detect_select,
    .low_voltage_detector, .auxiliary_voltage_detector, .reset_length_select,
    .input_halving_divider, .oscillator_input_en, .readout_protect,
    .flash_read_block, .flash_write_block, .package_select, .package_largest,
    .motor_output_reset_state, .motor_output_drive_n);
  user_mem_model u_user_mem_model (.clk(pclk), .rst_n(presetn),
    .req(user_mem_erase_req), .slow(slow), .done(user_mem_erase_done));
  // ****************************************
  // Checking
  // ****************************************
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    {test_mode, in_circuit_programming_mode} <= 2'($random(seed));
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) rcnt <= 16'h0000;
    else if (cpu_reset_n) rcnt <= 16'h0000;
    else rcnt <= rcnt + 16'h0001;
  end
  task cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    begin
      checks++;
      if (g !== e) begin
        miscompares++;
        $display("MISMATCH %s exp %h got %h", n, e, g);
      end
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1)
      cmp("apb", apb_q.pop_front(), {pslverr, prdata});
  end
  // Settings and phase length are judged once the CPU is let go.
  always @(posedge cpu_reset_n) begin
    #1;
    cmp("cfg", cfg_q.pop_front(), {rcnt, cfg_now});
  end
  function automatic logic [32:0] exp_cfg(input logic [15:0] o);
    logic [1:0] v, m;
    begin
      v = o[4:3];
      m = o[9:8];
      exp_cfg = {16'(((!o[5] || !o[2]) ? LONG : SHORT) + 2), o[7], o[6],
        !o[6], o[5], v, v != 2'h2, v[1] == v[0], o[2], !o[1], !o[0],
        o[15:13], o[15], !(m[1] ^ m[0]), m == 2'h2};
    end
  endfunction
  // ****************************************
  // Drivers
  // ****************************************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] e);
    begin
      apb_q.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wait_run;
    for (i = 0; i < 100 && cpu_reset_n !== 1'b1; i++) @(posedge pclk);
    @(posedge pclk);
  endtask
  task rst(input logic [15:0] o);
    begin
      cfg_q.push_back(exp_cfg(o));
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wait_run();
    end
  endtask
  task prog(input logic [15:0] o, input logic [15:0] now);
    begin
      apb(1'b1, 12'h004, {16'h0000, o}, '0);
      apb(1'b1, 12'h000, 32'h0000_0001, '0);
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h00C, '0, {17'h0_0000, now});
    end
  endtask
  task test_done;
    begin
      if (miscompares == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #100000;
    miscompares++;
    $display("MISMATCH watchdog exp done got timeout");
    test_done();
  end
  initial begin
    rst(16'hFFFF);
    apb(1'b1, 12'h004, '0, {1'b1, 32'h0000_0000});
    programming_mode <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h004, '0, {1'b0, 32'h0000_FFFF});
    apb(1'b0, 12'h010, '0, {1'b1, 32'h0000_0000});
    for (k = 0; k < 5; k++) begin
      ob = 16'($random(seed));
      ob[4:3] = 2'(k);
      ob[9:8] = ~2'(k);
      ob[0] = 1'b1;
      if (k == 1) begin
        ob[5] = 1'b0;
        ob[2] = 1'b1;
      end
      if (k == 2) ob[2] = 1'b0;
      prog(ob, ob);
      rst(ob);
    end
    ob = 16'h01E7;
    prog(ob, ob);
    rst(ob);
    sw_watchdog_enable <= 1'b1;
    halt_entry <= 1'b1;
    cfg_q.push_back(exp_cfg(ob));
    @(posedge pclk);
    halt_entry <= 1'b0;
    repeat (2) @(posedge pclk);
    wait_run();
    sw_watchdog_enable <= 1'b0;
    halt_entry <= 1'b1;
    @(posedge pclk);
    halt_entry <= 1'b0;
    repeat (3) @(posedge pclk);
    wakeup <= 1'b1;
    @(posedge pclk);
    wakeup <= 1'b0;
    for (i = 0; i < 100 && halt_exit_done !== 1'b1; i++) @(posedge pclk);
    cmp("wake", 2'b10, {halt_exit_done, cpu_halted});
    ob = 16'h02FE;
    prog(ob, ob);
    rst(ob);
    prog(16'h02FF, ob);
    apb(1'b0, 12'h008, '0, {1'b0, 32'h0000_0024});
    slow <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0002, '0);
    repeat (2) @(posedge pclk);
    for (i = 0; i < 100 && user_mem_erase_req !== 1'b0; i++)
      @(posedge pclk);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00C, '0, {1'b0, 32'h0000_FFFF});
    rst(16'hFFFF);
    cmp("queue", '0, 33'(cfg_q.size() + apb_q.size()));
    test_done();
  end
endmodule
